// ### bench/flag_ref_pkg.sv
// reference flag actions shared by the bench and the checker
package flag_ref_pkg;
	import status_flag_pkg::*;

	// ==========================================================================
	// action table, cc in the low pair
	function automatic actset_t actsOf(instr_t i);
		logic        d;
		logic [11:0] v;
		d = (i.dst == DST_DREG);
		case (i.cls)
			CLS_MOVE_ACC:   v = 12'h33C;
			CLS_ZEXT_HALF:  v = 12'h2A4;
			CLS_LOGIC:      v = 12'h294;
			CLS_ADD_SHIFT:  v = d ? 12'h1D4 : 12'h000;
			CLS_ASHIFT_ACC: v = 12'h0D4;
			CLS_LSHIFT:     v = (i.dst == DST_PREG) ? 12'h3FC : 12'h314;
			CLS_ADD_IMM:    v = d ? 12'h154 : 12'h000;
			CLS_DIVIDE:     v = 12'h7FC;
			CLS_MODIFY_INC: v = d ? 12'h154 : ((i.dst == DST_ACC) ? 12'h3FC : 12'h000);
			CLS_MULTIPLY:   v = 12'h300;
			CLS_TESTSET:    v = 12'h001;
			CLS_QUAD_BYTE:  v = 12'h3FC;
			CLS_VEC_ADDSUB: v = 12'h164;
			CLS_VEC_MAC:    v = 12'h100;
			CLS_NEGATE:     v = d ? 12'h1D4 : 12'h3D4;
			default:        v = 12'h000;
		endcase
		return actset_t'(v);
	endfunction

	// undefined flags follow the load switch
	function automatic flags_t applyActs(flags_t cur, flags_t res, actset_t a, logic ul);
		logic [11:0] v;
		flags_t      n;
		v = a;
		n = cur;
		for (int k = 0; k < 6; k++) begin
			case (v[2*k +: 2])
				ACT_LOAD:  n[k] = res[k];
				ACT_CLEAR: n[k] = 1'b0;
				ACT_UNDEF: n[k] = ul ? res[k] : cur[k];
				default:   n[k] = cur[k];
			endcase
		end
		return n;
	endfunction
endpackage

// ### bench/status_flag_update_sva.sv
// concurrent checks on the status flag block ports
module status_flag_update_sva (
	// clock and reset
	input wire logic                      core_clk,
	input wire logic                      arst_n,
	// instruction side
	input wire logic                      instrValid,
	input wire status_flag_pkg::instr_t   instr,
	// core state
	input wire status_flag_pkg::flags_t   arithStatus,
	input wire logic                      haltedOut,
	input wire logic                      privFault,
	// register bus
	input wire status_flag_pkg::axi_req_t axiReq,
	input wire status_flag_pkg::axi_rsp_t axiRsp
);
	timeunit 1ns;
	timeprecision 100ps;
	import status_flag_pkg::*;
	import flag_ref_pkg::*;

	flags_t nx0;
	flags_t nx1;
	logic   wrIdle;
	logic   go;
	logic   userIdle;
	logic   superIdle;
	logic   syncNow;

	// no register write executes while any of these is high
	assign wrIdle    = axiRsp.awready | axiRsp.wready | axiRsp.bvalid;
	assign go        = instrValid & ~haltedOut & wrIdle;
	assign userIdle  = instrValid & ~haltedOut & (instr.cls == CLS_IDLE) & instr.userMode;
	assign superIdle = instrValid & ~haltedOut & (instr.cls == CLS_IDLE) & ~instr.userMode;
	assign syncNow   = instrValid & ~haltedOut & (instr.cls == CLS_SYSTEM_SYNC_INSTR);
	assign nx0       = applyActs(arithStatus, instr.result, actsOf(instr), 1'b0);
	assign nx1       = applyActs(arithStatus, instr.result, actsOf(instr), 1'b1);

	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	property pUpd(cls_t c);
		go && instr.cls == c |=> arithStatus == $past(nx0) || arithStatus == $past(nx1);
	endproperty

	// ==========================================================================
	// halt and privilege
	AST_USER_IDLE_FAULT: assert property (userIdle |=> privFault)
		else $error("no fault on user idle");
	AST_FAULT_CAUSE: assert property (privFault |-> $past(userIdle))
		else $error("fault without user idle");
	AST_USER_NO_ARM: assert property (userIdle ##1 syncNow |=> !haltedOut)
		else $error("user idle armed halt");
	AST_HALT_SEQ: assert property (superIdle ##1 syncNow |=> haltedOut)
		else $error("idle then sync did not halt");
	AST_HALT_CAUSE: assert property ($rose(haltedOut) |-> $past(syncNow))
		else $error("halt without sync");
	AST_HALT_HOLD: assert property (haltedOut && wrIdle |=> haltedOut && $stable(arithStatus))
		else $error("halted core changed state");

	// ==========================================================================
	// flag update per class
	AST_KEEP_MOVES: assert property (pUpd(CLS_NOFLAG))
		else $error("flags changed on keep class");
	AST_MOVE_ACC: assert property (pUpd(CLS_MOVE_ACC))
		else $error("flags after acc move");
	AST_ZEXT_HALF: assert property (pUpd(CLS_ZEXT_HALF))
		else $error("flags after zero extend");
	AST_LOGIC_OP: assert property (pUpd(CLS_LOGIC))
		else $error("flags after logic op");
	AST_ADD_SHIFT: assert property (pUpd(CLS_ADD_SHIFT))
		else $error("flags after add shift");
	AST_ASHIFT_ACC: assert property (pUpd(CLS_ASHIFT_ACC))
		else $error("flags after acc shift");
	AST_LSHIFT: assert property (pUpd(CLS_LSHIFT))
		else $error("flags after logical shift");
	AST_ADD_IMM: assert property (pUpd(CLS_ADD_IMM))
		else $error("flags after add immediate");
	AST_DIVIDE: assert property (pUpd(CLS_DIVIDE))
		else $error("flags after divide step");
	AST_MODIFY_INC: assert property (pUpd(CLS_MODIFY_INC))
		else $error("flags after modify increment");
	AST_MULTIPLY: assert property (pUpd(CLS_MULTIPLY))
		else $error("flags after multiply");
	AST_TESTSET: assert property (pUpd(CLS_TESTSET))
		else $error("flags after test and set");
	AST_QUAD_BYTE: assert property (pUpd(CLS_QUAD_BYTE))
		else $error("flags after quad byte op");
	AST_VEC_ADDSUB: assert property (pUpd(CLS_VEC_ADDSUB))
		else $error("flags after vector add");
	AST_VEC_MAC: assert property (pUpd(CLS_VEC_MAC))
		else $error("flags after vector mac");
	AST_NEGATE: assert property (pUpd(CLS_NEGATE))
		else $error("flags after negate");

	cover property ($rose(haltedOut));
	cover property (privFault);
	cover property (axiRsp.rvalid && axiRsp.rresp == 2'b11);
endmodule

bind status_flag_update status_flag_update_sva CHK (
	.core_clk   (core_clk),
	.arst_n     (arst_n),
	.instrValid (instrValid),
	.instr      (instr),
	.arithStatus(arithStatus),
	.haltedOut  (haltedOut),
	.privFault  (privFault),
	.axiReq     (axiReq),
	.axiRsp     (axiRsp)
);

// ### bench/tb_top.sv
// self-checking bench for the status flag update block
`include "status_flag_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import status_flag_pkg::*;
	import flag_ref_pkg::*;

	logic        core_clk;
	logic        arst_n;
	logic        instrValid;
	instr_t      instr;
	flags_t      arithStatus;
	flags_t      expFlags;
	logic        haltedOut;
	logic        privFault;
	logic        halted;
	logic        armed;
	logic        pfS;
	logic        ul;
	axi_req_t    axiReq;
	axi_rsp_t    axiRsp;
	logic [33:0] flagQ[$];
	logic [33:0] busQ[$];
	int          err_total;
	int          checks_done;
	int          seed;

	status_flag_update DUT (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.instrValid (instrValid),
		.instr      (instr),
		.arithStatus(arithStatus),
		.haltedOut  (haltedOut),
		.privFault  (privFault),
		.axiReq     (axiReq),
		.axiRsp     (axiRsp)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic testEnd(input string s);
		$display("test %s finished", s);
	endtask

	// ==========================================================================
	// result monitor
	always @(posedge core_clk) begin
		if (axiRsp.rvalid && axiReq.rready) begin
			chk({axiRsp.rresp, axiRsp.rdata}, busQ.pop_front());
		end
		if (axiRsp.bvalid && axiReq.bready) begin
			chk({32'h0000_0000, axiRsp.bresp}, busQ.pop_front());
		end
		if (instrValid) begin
			#1;
			chk({26'h000_0000, haltedOut, privFault, arithStatus}, flagQ.pop_front());
		end
	end

	// ==========================================================================
	// drivers with expectation model
	task automatic issue(input cls_t c, input dst_t d, input logic u, input flags_t r);
		instr_t i;
		logic   pf;
		i = '{cls: c, dst: d, userMode: u, result: r};
		pf = 1'b0;
		@(posedge core_clk);
		instrValid <= 1'b1;
		instr <= i;
		if (!halted) begin
			if (c == CLS_IDLE && u) begin
				pf = 1'b1;
				pfS = 1'b1;
			end
			expFlags = applyActs(expFlags, r, actsOf(i), ul);
			halted = armed && c == CLS_SYSTEM_SYNC_INSTR;
			armed = c == CLS_IDLE && !u;
		end
		flagQ.push_back({26'h000_0000, halted, pf, expFlags});
	endtask

	task automatic quiet();
		@(posedge core_clk);
		instrValid <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		busQ.push_back({32'h0000_0000, er});
		@(posedge core_clk);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (!aw && axiRsp.awready) begin
				aw = 1'b1;
				axiReq.awvalid <= 1'b0;
			end
			if (!w && axiRsp.wready) begin
				w = 1'b1;
				axiReq.wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (!axiRsp.bvalid);
		axiReq.bready <= 1'b0;
		if (er == `RESP_OKAY) begin
			case (a[3:0])
				`OFF_STATUS: expFlags = flags_t'(d[5:0]);
				`OFF_CTRL:   ul = d[0];
				`OFF_WAKE:   halted = halted & ~d[0];
				default:     ;
			endcase
		end
	endtask

	task automatic rd(input logic [31:0] a);
		logic [33:0] e;
		case (a[3:0])
			`OFF_STATUS: e = {`RESP_OKAY, 26'h000_0000, expFlags};
			`OFF_CTRL:   e = {`RESP_OKAY, 31'h0000_0000, ul};
			`OFF_EVENT:  e = {`RESP_OKAY, 29'h0000_0000, armed, pfS, halted};
			`OFF_WAKE:   e = {`RESP_OKAY, `DATA_ZERO};
			default:     e = {`RESP_DECERR, `DATA_ZERO};
		endcase
		busQ.push_back(e);
		if (a[3:0] == `OFF_EVENT) begin
			pfS = 1'b0;
		end
		@(posedge core_clk);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do @(posedge core_clk); while (!axiRsp.arready);
		axiReq.arvalid <= 1'b0;
		do @(posedge core_clk); while (!axiRsp.rvalid);
		axiReq.rready <= 1'b0;
	endtask

	// ==========================================================================
	// main sequence
	initial begin
		arst_n = 1'b0;
		instrValid = 1'b0;
		instr = '0;
		axiReq = '0;
		axiReq.wstrb = 4'hF;
		expFlags = '0;
		{halted, armed, pfS, ul} = 4'h0;
		err_total = 0;
		checks_done = 0;
		seed = 32'h4A24_9162;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		// reset values, alias and unmapped place
		for (int k = 0; k < 17; k += 4) rd(32'(k));
		rd(32'h0000_0002);
		wr(32'h0000_0002, 32'h0000_003F, `RESP_DECERR);
		wr(32'(`OFF_STATUS), 32'h0000_0015, `RESP_OKAY);
		rd(32'(`OFF_STATUS));
		testEnd("registers");
		// every flag class and destination, undefined kept then loaded
		for (int m = 0; m < 2; m++) begin
			wr(32'(`OFF_CTRL), 32'(m), `RESP_OKAY);
			rd(32'(`OFF_CTRL));
			rd(32'(`OFF_STATUS));
			for (int k = 0; k < 64; k++) begin
				issue(cls_t'(k[5:2]), dst_t'(k[1:0]), 1'b0, flags_t'(6'($random(seed))));
			end
			quiet();
			rd(32'(`OFF_STATUS));
		end
		testEnd("flag classes");
		issue(CLS_IDLE, DST_DREG, 1'b1, 6'h3F);
		issue(CLS_SYSTEM_SYNC_INSTR, DST_DREG, 1'b0, 6'h3F);
		issue(CLS_CORE_SYNC_INSTR, DST_DREG, 1'b0, 6'h3F);
		quiet();
		rd(32'(`OFF_EVENT));
		rd(32'(`OFF_EVENT));
		testEnd("privilege");
		issue(CLS_IDLE, DST_DREG, 1'b0, 6'h00);
		issue(CLS_NOFLAG, DST_DREG, 1'b0, 6'h3F);
		issue(CLS_SYSTEM_SYNC_INSTR, DST_DREG, 1'b0, 6'h00);
		issue(CLS_IDLE, DST_DREG, 1'b0, 6'h00);
		issue(CLS_SYSTEM_SYNC_INSTR, DST_DREG, 1'b0, 6'h00);
		issue(CLS_LOGIC, DST_DREG, 1'b0, 6'h3F);
		quiet();
		rd(32'(`OFF_EVENT));
		wr(32'(`OFF_WAKE), 32'h0000_0001, `RESP_OKAY);
		rd(32'(`OFF_EVENT));
		issue(CLS_LOGIC, DST_DREG, 1'b0, 6'h3F);
		quiet();
		// let the monitor finish the last compare
		@(posedge core_clk);
		testEnd("halt");
		close_out();
	end
endmodule

// ### core/status_flag_cfg.svh
// offsets, field positions, reset values and codes for the status flag block
`ifndef STATUS_FLAG_CFG_SVH
`define STATUS_FLAG_CFG_SVH

// ==========================================================================
// register byte offsets
`define OFF_STATUS      4'h0
`define OFF_CTRL        4'h4
`define OFF_EVENT       4'h8
`define OFF_WAKE        4'hC
`define ADDR_BITS       4

// ==========================================================================
// field positions
`define CTRL_UNDEF_LOAD 0
`define EVT_HALTED      0
`define EVT_PRIV_FAULT  1
`define EVT_IDLE_ARMED  2
`define WAKE_RELEASE    0
`define FLAG_BITS       6

// ==========================================================================
// reset values
`define FLAGS_RST       6'h00
`define CTRL_RST        1'b0
`define DATA_ZERO       32'h0000_0000

// ==========================================================================
// bus answers
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11

`endif

// ### core/status_flag_pkg.sv
// types shared by the status flag update block
package status_flag_pkg;

	// instruction classes as seen by the flag logic
	typedef enum logic [4:0] {
		CLS_NOFLAG     = 5'h00,
		CLS_MOVE_ACC   = 5'h01,
		CLS_ZEXT_HALF  = 5'h02,
		CLS_LOGIC      = 5'h03,
		CLS_ADD_SHIFT  = 5'h04,
		CLS_ASHIFT_ACC = 5'h05,
		CLS_LSHIFT     = 5'h06,
		CLS_ADD_IMM    = 5'h07,
		CLS_DIVIDE     = 5'h08,
		CLS_MODIFY_INC = 5'h09,
		CLS_MULTIPLY   = 5'h0A,
		CLS_TESTSET    = 5'h0B,
		CLS_QUAD_BYTE  = 5'h0C,
		CLS_VEC_ADDSUB = 5'h0D,
		CLS_VEC_MAC    = 5'h0E,
		CLS_NEGATE     = 5'h0F,
		CLS_IDLE       = 5'h10,
		CLS_SYSTEM_SYNC_INSTR      = 5'h11,
		CLS_CORE_SYNC_INSTR      = 5'h12
	} cls_t;

	// destination register kind
	typedef enum logic [1:0] {
		DST_DREG = 2'b00,
		DST_PREG = 2'b01,
		DST_ACC  = 2'b10,
		DST_HALF = 2'b11
	} dst_t;

	// per-flag action
	typedef enum logic [1:0] {
		ACT_KEEP  = 2'b00,
		ACT_LOAD  = 2'b01,
		ACT_CLEAR = 2'b10,
		ACT_UNDEF = 2'b11
	} act_t;

	// the six kept arithmetic status flags, cc in bit 0
	typedef struct packed {
		logic quotFlag;
		logic ovfMirror;
		logic carryMirror;
		logic negFlag;
		logic zeroFlag;
		logic condFlag;
	} flags_t;

	typedef struct packed {
		act_t quotFlag;
		act_t ovfMirror;
		act_t carryMirror;
		act_t negFlag;
		act_t zeroFlag;
		act_t condFlag;
	} actset_t;

	// one retiring instruction
	typedef struct packed {
		cls_t   cls;
		dst_t   dst;
		logic   userMode;
		flags_t result;
	} instr_t;

	// AXI4-Lite request and answer groups
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;

endpackage

// ### core/status_flag_update.sv
// status flag update logic with halt sequencing and an AXI4-Lite register slave
//
// Function
// - halt-and-wait in user mode is refused as a protected instruction
// - halt-and-wait halts only when system sync directly follows it
// - only cc, zero, negative, carry mirror, overflow mirror, quotient flags exist
// - jumps, calls, returns, loops, loads, stores, stack, plain moves keep flags
// - accumulator to data register move leaves zero, negative, overflow undefined
// - zero-extend half move loads zero, clears negative, carry and overflow
// - byte, sign-extend and bitwise ops load zero, negative; clear carry, overflow
// - add-with-shift to data register loads zero, negative, overflow; carry undefined
// - arithmetic shift to accumulator loads zero, negative; carry undefined
// - logical shift: pointer four undefined; data loads zero, negative, overflow undefined
// - add immediate to data register loads four flags; pointer adds keep all
// - divide steps load quotient flag; other four undefined
// - modify-increment: data register loads four flags, accumulator leaves four undefined
// - multiply and multiply-accumulate leave overflow undefined, others kept
// - test-and-set loads cc from its test, all others kept
// - quad byte operations leave zero, negative, carry, overflow undefined
// - vector add/subtract loads zero, carry, overflow; clears negative
// - vector multiply-accumulate loads overflow only
// - negate to data register loads zero, negative, overflow; carry undefined
// - register reads are not shielded from speculation; a read always acts
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "status_flag_cfg.svh"

module status_flag_update (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      arst_n,
	// retiring instruction
	input  wire logic                      instrValid,
	input  wire status_flag_pkg::instr_t   instr,
	// core state
	output      status_flag_pkg::flags_t   arithStatus,
	output      logic                      haltedOut,
	output      logic                      privFault,
	// register bus
	input  wire status_flag_pkg::axi_req_t axiReq,
	output      status_flag_pkg::axi_rsp_t axiRsp
);
	import status_flag_pkg::*;

	// ======================================================================
	// flag action decode
	function automatic actset_t classAct(input cls_t cls, input dst_t dst);
		actset_t a;
		a = '{ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP};
		case (cls)
			CLS_MOVE_ACC: begin
				a.zeroFlag  = ACT_UNDEF;
				a.negFlag   = ACT_UNDEF;
				a.ovfMirror = ACT_UNDEF;
			end
			CLS_ZEXT_HALF: begin
				a.zeroFlag    = ACT_LOAD;
				a.negFlag     = ACT_CLEAR;
				a.carryMirror = ACT_CLEAR;
				a.ovfMirror   = ACT_CLEAR;
			end
			CLS_LOGIC: begin
				a.zeroFlag    = ACT_LOAD;
				a.negFlag     = ACT_LOAD;
				a.carryMirror = ACT_CLEAR;
				a.ovfMirror   = ACT_CLEAR;
			end
			CLS_ADD_SHIFT: begin
				if (dst == DST_DREG) begin
					a.zeroFlag    = ACT_LOAD;
					a.negFlag     = ACT_LOAD;
					a.ovfMirror   = ACT_LOAD;
					a.carryMirror = ACT_UNDEF;
				end
			end
			CLS_ASHIFT_ACC: begin
				a.zeroFlag    = ACT_LOAD;
				a.negFlag     = ACT_LOAD;
				a.carryMirror = ACT_UNDEF;
			end
			CLS_LSHIFT: begin
				if (dst == DST_PREG) begin
					a.zeroFlag    = ACT_UNDEF;
					a.negFlag     = ACT_UNDEF;
					a.carryMirror = ACT_UNDEF;
					a.ovfMirror   = ACT_UNDEF;
				end else begin
					a.zeroFlag  = ACT_LOAD;
					a.negFlag   = ACT_LOAD;
					a.ovfMirror = ACT_UNDEF;
				end
			end
			CLS_ADD_IMM: begin
				if (dst == DST_DREG) begin
					a.zeroFlag    = ACT_LOAD;
					a.negFlag     = ACT_LOAD;
					a.carryMirror = ACT_LOAD;
					a.ovfMirror   = ACT_LOAD;
				end
			end
			CLS_DIVIDE: begin
				a.quotFlag    = ACT_LOAD;
				a.zeroFlag    = ACT_UNDEF;
				a.negFlag     = ACT_UNDEF;
				a.carryMirror = ACT_UNDEF;
				a.ovfMirror   = ACT_UNDEF;
			end
			CLS_MODIFY_INC: begin
				if (dst == DST_DREG) begin
					a.zeroFlag    = ACT_LOAD;
					a.negFlag     = ACT_LOAD;
					a.carryMirror = ACT_LOAD;
					a.ovfMirror   = ACT_LOAD;
				end else if (dst == DST_ACC) begin
					a.zeroFlag    = ACT_UNDEF;
					a.negFlag     = ACT_UNDEF;
					a.carryMirror = ACT_UNDEF;
					a.ovfMirror   = ACT_UNDEF;
				end
			end
			CLS_MULTIPLY: begin
				a.ovfMirror = ACT_UNDEF;
			end
			CLS_TESTSET: begin
				a.condFlag = ACT_LOAD;
			end
			CLS_QUAD_BYTE: begin
				a.zeroFlag    = ACT_UNDEF;
				a.negFlag     = ACT_UNDEF;
				a.carryMirror = ACT_UNDEF;
				a.ovfMirror   = ACT_UNDEF;
			end
			CLS_VEC_ADDSUB: begin
				a.zeroFlag    = ACT_LOAD;
				a.negFlag     = ACT_CLEAR;
				a.carryMirror = ACT_LOAD;
				a.ovfMirror   = ACT_LOAD;
			end
			CLS_VEC_MAC: begin
				a.ovfMirror = ACT_LOAD;
			end
			CLS_NEGATE: begin
				a.zeroFlag    = ACT_LOAD;
				a.negFlag     = ACT_LOAD;
				a.carryMirror = ACT_UNDEF;
				a.ovfMirror   = (dst == DST_DREG) ? ACT_LOAD : ACT_UNDEF;
			end
			default: begin
				a = '{ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP, ACT_KEEP};
			end
		endcase
		return a;
	endfunction

	// one flag's next value; undefined takes the result or keeps, per control
	function automatic logic applyAct(input act_t act, input logic old, input logic res,
		input logic undefLoad);
		logic v;
		v = old;
		case (act)
			ACT_LOAD:  v = res;
			ACT_CLEAR: v = 1'b0;
			ACT_UNDEF: v = undefLoad ? res : old;
			default:   v = old;
		endcase
		return v;
	endfunction

	// ======================================================================
	// state
	flags_t              flags_q;
	flags_t              flags_d;
	logic                undefLoad_q;
	logic                idleArmed_q;
	logic                halted_q;
	logic                privFault_q;
	logic                faultSticky_q;
	logic                awHeld_q;
	logic                wHeld_q;
	logic [`ADDR_BITS-1:0] awAddr_q;
	logic [31:0]         wData_q;
	logic [3:0]          wStrb_q;
	logic                awready_q;
	logic                wready_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                arready_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;

	logic                issue;
	logic                wrFire;
	logic                rdFire;
	logic                wrLow;
	logic [`ADDR_BITS-1:0] rdAddr;
	actset_t             act;

	// instructions retire only while running
	assign issue  = instrValid && !halted_q;
	assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
	assign rdFire = axiReq.arvalid && arready_q;
	assign wrLow  = wStrb_q[0];
	assign rdAddr = axiReq.araddr[`ADDR_BITS-1:0];
	assign act    = classAct(instr.cls, instr.dst);

	// ======================================================================
	// flag update
	// six flags only, decoded per class
	always_comb begin
		flags_d = flags_q;
		if (wrFire && awAddr_q == `OFF_STATUS && wrLow) begin
			flags_d = flags_t'(wData_q[`FLAG_BITS-1:0]);
		end
		if (issue && !(instr.cls == CLS_IDLE && instr.userMode)) begin
			flags_d.condFlag    = applyAct(act.condFlag, flags_d.condFlag,
				instr.result.condFlag, undefLoad_q);
			flags_d.zeroFlag    = applyAct(act.zeroFlag, flags_d.zeroFlag,
				instr.result.zeroFlag, undefLoad_q);
			flags_d.negFlag     = applyAct(act.negFlag, flags_d.negFlag,
				instr.result.negFlag, undefLoad_q);
			flags_d.carryMirror = applyAct(act.carryMirror, flags_d.carryMirror,
				instr.result.carryMirror, undefLoad_q);
			flags_d.ovfMirror   = applyAct(act.ovfMirror, flags_d.ovfMirror,
				instr.result.ovfMirror, undefLoad_q);
			flags_d.quotFlag    = applyAct(act.quotFlag, flags_d.quotFlag,
				instr.result.quotFlag, undefLoad_q);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= flags_t'(`FLAGS_RST);
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			undefLoad_q <= `CTRL_RST;
		end else if (wrFire && awAddr_q == `OFF_CTRL && wrLow) begin
			undefLoad_q <= wData_q[`CTRL_UNDEF_LOAD];
		end
	end

	// ======================================================================
	// halt sequencing
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			idleArmed_q <= 1'b0;
			halted_q    <= 1'b0;
		end else begin
			if (issue) begin
				// halt only if sync follows directly
				idleArmed_q <= instr.cls == CLS_IDLE && !instr.userMode;
				if (idleArmed_q && instr.cls == CLS_SYSTEM_SYNC_INSTR) begin
					halted_q <= 1'b1;
				end
			end else if (halted_q && wrFire && awAddr_q == `OFF_WAKE && wrLow
				&& wData_q[`WAKE_RELEASE]) begin
				halted_q <= 1'b0;
			end
		end
	end

	// user-mode idle is a protection fault
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			privFault_q <= 1'b0;
		end else begin
			privFault_q <= issue && instr.cls == CLS_IDLE && instr.userMode;
		end
	end

	// event read clears the sticky bit; a set in the same cycle wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			faultSticky_q <= 1'b0;
		end else if (issue && instr.cls == CLS_IDLE && instr.userMode) begin
			faultSticky_q <= 1'b1;
		end else if (rdFire && rdAddr == `OFF_EVENT) begin
			faultSticky_q <= 1'b0;
		end
	end

	// ======================================================================
	// AXI4-Lite write path
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_q  <= 1'b0;
			awready_q <= 1'b1;
			awAddr_q  <= '0;
		end else if (axiReq.awvalid && awready_q) begin
			awHeld_q  <= 1'b1;
			awready_q <= 1'b0;
			awAddr_q  <= axiReq.awaddr[`ADDR_BITS-1:0];
		end else if (wrFire) begin
			awHeld_q <= 1'b0;
		end else if (bvalid_q && axiReq.bready) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wHeld_q  <= 1'b0;
			wready_q <= 1'b1;
			wData_q  <= `DATA_ZERO;
			wStrb_q  <= 4'h0;
		end else if (axiReq.wvalid && wready_q) begin
			wHeld_q  <= 1'b1;
			wready_q <= 1'b0;
			wData_q  <= axiReq.wdata;
			wStrb_q  <= axiReq.wstrb;
		end else if (wrFire) begin
			wHeld_q <= 1'b0;
		end else if (bvalid_q && axiReq.bready) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wrFire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (awAddr_q == `OFF_STATUS || awAddr_q == `OFF_CTRL
				|| awAddr_q == `OFF_WAKE) ? `RESP_OKAY : `RESP_DECERR;
		end else if (bvalid_q && axiReq.bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ======================================================================
	// AXI4-Lite read path
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= `DATA_ZERO;
			rresp_q   <= `RESP_OKAY;
		end else if (rdFire) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= `RESP_OKAY;
			rdata_q   <= `DATA_ZERO;
			case (rdAddr)
				`OFF_STATUS: rdata_q <= {26'h000_0000, flags_q};
				`OFF_CTRL:   rdata_q <= {31'h0000_0000, undefLoad_q};
				`OFF_EVENT:  rdata_q <= {29'h0000_0000, idleArmed_q, faultSticky_q,
					halted_q};
				`OFF_WAKE:   rdata_q <= `DATA_ZERO;
				default:     rresp_q <= `RESP_DECERR;
			endcase
		end else if (rvalid_q && axiReq.rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ======================================================================
	// outputs
	assign arithStatus    = flags_q;
	assign haltedOut      = halted_q;
	assign privFault      = privFault_q;
	assign axiRsp.awready = awready_q;
	assign axiRsp.wready  = wready_q;
	assign axiRsp.bvalid  = bvalid_q;
	assign axiRsp.bresp   = bresp_q;
	assign axiRsp.arready = arready_q;
	assign axiRsp.rvalid  = rvalid_q;
	assign axiRsp.rdata   = rdata_q;
	assign axiRsp.rresp   = rresp_q;

endmodule
